//--- rtl/itv_top.sv
`timescale 1ns/100ps
`default_nettype none
module itv_top
  import itv_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // Trap sources
  input wire logic [1:0] SYSREQ_PIN,
  input wire logic [6:0] CORE_TRAP,
  input wire logic SW_TRAP_REQ,
  input wire logic [NUM_W-1:0] SW_TRAP_NUM,
  // Interrupt nodes
  input wire logic [NODE_N-1:0] NODE_REQ,
  // CPU side
  input wire logic TRAP_RET,
  output logic VEC_VALID,
  output itv_vec_t VEC,
  output logic TRAP_ACTIVE,
  output logic IRQ
);
  logic [1:0] sr_lvl;
  logic [1:0] sr_prev_r;
  logic [1:0] sr_evt;
  logic [CAUSE_N-1:0] cause;
  logic [CAUSE_N-1:0] flag_r;
  logic [CAUSE_N-1:0] pend_r;
  logic [CAUSE_N-1:0] clr_pend;
  logic [NODE_N-1:0] node_pend_r;
  logic [SEG_W-1:0] seg_r;
  logic [SC_W-1:0] sc_r;
  logic [EVT_N-1:0] evt_r;
  logic [EVT_N-1:0] evt_nxt;
  logic [EVT_N-1:0] mask_r;
  logic [EVT_N-1:0] mask_nxt;
  logic sw_pend_r;
  logic [NUM_W-1:0] sw_num_r;
  logic rst_pend_r;
  itv_lvl_t lvl_r;
  itv_lvl_t lvl_nxt;
  itv_lvl_t prev_r;
  itv_lvl_t prev_nxt;
  itv_lvl_t base_lvl;
  logic take_rst;
  logic take_a;
  logic take_b;
  logic take_sw;
  logic take_node;
  logic [NUM_W-1:0] num_nxt;
  logic [NUM_W-1:0] node_num;
  logic [$clog2(NODE_N)-1:0] node_sel;
  logic [1:0] a_sel;
  itv_addr_t addr_nxt;
  logic addr_ph;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  logic [31:0] rd_data;

  itv_sync #(
    .W(2)
  ) u_sync (
    .clk(CLK),
    .rst_n(RSTN),
    .din(SYSREQ_PIN),
    .dout(sr_lvl)
  );

  assign sr_evt = sr_lvl & ~sr_prev_r;
  // Cause order: sysreq 0, overflow, underflow, break, sysreq 1, opcode, access, protect, operand
  assign cause = {CORE_TRAP[6:3], sr_evt[1], CORE_TRAP[2:0], sr_evt[0]};

  // AHB-Lite address and data phases; zero wait states, always OKAY
  assign addr_ph = HSEL & HREADY & HTRANS[1];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_r <= addr_ph & HWRITE & (HADDR[31:8] == 24'h00_0000);
      waddr_r <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  always_comb begin
    case (HADDR[7:0])
      OFS_VEC_SEG: rd_data = 32'(seg_r);
      OFS_CPU_CTRL_ONE: rd_data = 32'(sc_r);
      OFS_TRAP_FLAG: rd_data = 32'(flag_r);
      OFS_IRQ_STAT: rd_data = 32'(evt_r);
      OFS_IRQ_MASK: rd_data = 32'(mask_r);
      OFS_SVC_STAT: rd_data = 32'({pend_r, prev_r, lvl_r});
      default: rd_data = 32'h0000_0000;
    endcase
    if (HADDR[31:8] != 24'h00_0000) begin
      rd_data = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_ph && !HWRITE) begin
      HRDATA <= rd_data;
    end
  end

  // Vector table placement
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      seg_r <= RST_SEG;
      sc_r <= RST_SC;
    end else if (wr_pend_r) begin
      if (waddr_r == OFS_VEC_SEG) begin
        seg_r <= HWDATA[SEG_W-1:0];
      end
      if (waddr_r == OFS_CPU_CTRL_ONE) begin
        sc_r <= HWDATA[SC_W-1:0];
      end
    end
  end

  // Trap flags: write one clears, a new cause in the same cycle wins
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      flag_r <= '0;
      sr_prev_r <= 2'b00;
    end else begin
      sr_prev_r <= sr_lvl;
      if (wr_pend_r && waddr_r == OFS_TRAP_FLAG) begin
        flag_r <= (flag_r & ~HWDATA[CAUSE_N-1:0]) | cause;
      end else begin
        flag_r <= flag_r | cause;
      end
    end
  end

  // Pending traps, independent of software flag clearing
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~clr_pend) | cause;
    end
  end

  // Interrupt node pending bits
  genvar gi;
  generate
    for (gi = 0; gi < NODE_N; gi++) begin : g_node
      always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
          node_pend_r[gi] <= 1'b0;
        end else begin
          node_pend_r[gi] <= (node_pend_r[gi] & ~(take_node && node_sel == gi)) | NODE_REQ[gi];
        end
      end
    end
  endgenerate

  // Software trap request and reset entry
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sw_pend_r <= 1'b0;
      sw_num_r <= TN_RESET;
      rst_pend_r <= 1'b1;
    end else begin
      if (SW_TRAP_REQ) begin
        sw_pend_r <= 1'b1;
        sw_num_r <= SW_TRAP_NUM;
      end else if (take_sw) begin
        sw_pend_r <= 1'b0;
      end
      if (take_rst) begin
        rst_pend_r <= 1'b0;
      end
    end
  end

  // Arbitration: reset entry, class A, class B, software trap, nodes
  always_comb begin
    a_sel = 2'd0;
    for (int i = CLASS_A_N - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        a_sel = 2'(i);
      end
    end
    node_sel = '0;
    for (int i = 0; i < NODE_N; i++) begin
      if (node_pend_r[i]) begin
        node_sel = ($clog2(NODE_N))'(i);
      end
    end
    node_num = itv_node_num(int'(node_sel));
    take_rst = 1'b0;
    take_a = 1'b0;
    take_b = 1'b0;
    take_sw = 1'b0;
    take_node = 1'b0;
    num_nxt = TN_RESET;
    clr_pend = '0;
    if (!VEC_VALID) begin
      if (rst_pend_r) begin
        take_rst = 1'b1;
      end else if (|pend_r[CLASS_A_N-1:0] && lvl_r != LVL_A) begin
        take_a = 1'b1;
        num_nxt = TN_SYSREQ0 + NUM_W'({a_sel, 1'b0});
        clr_pend[a_sel] = 1'b1;
      end else if (|pend_r[CAUSE_N-1:CLASS_A_N] && lvl_r == LVL_NONE) begin
        take_b = 1'b1;
        num_nxt = TN_CLASS_B;
        clr_pend[CAUSE_N-1:CLASS_A_N] = '1;
      end else if (sw_pend_r) begin
        take_sw = 1'b1;
        num_nxt = sw_num_r;
      end else if (|node_pend_r && lvl_r == LVL_NONE) begin
        take_node = 1'b1;
        num_nxt = node_num;
      end
    end
  end

  itv_vec_calc u_calc (
    .num(num_nxt),
    .seg(seg_r),
    .sc(sc_r),
    .addr(addr_nxt)
  );

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      VEC_VALID <= 1'b0;
      VEC <= '0;
    end else begin
      VEC_VALID <= take_rst | take_a | take_b | take_sw | take_node;
      if (take_rst | take_a | take_b | take_sw | take_node) begin
        VEC.num <= num_nxt;
        VEC.addr <= addr_nxt;
      end
    end
  end

  // Trap service level, one saved level (only class A can nest)
  always_comb begin
    base_lvl = lvl_r;
    prev_nxt = prev_r;
    if (TRAP_RET) begin
      case (lvl_r)
        LVL_A: base_lvl = prev_r;
        LVL_B: base_lvl = LVL_NONE;
        default: base_lvl = LVL_NONE;
      endcase
      prev_nxt = LVL_NONE;
    end
    lvl_nxt = base_lvl;
    if (take_a) begin
      prev_nxt = base_lvl;
      lvl_nxt = LVL_A;
    end else if (take_b) begin
      prev_nxt = base_lvl;
      lvl_nxt = LVL_B;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lvl_r <= LVL_NONE;
      prev_r <= LVL_NONE;
      TRAP_ACTIVE <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      prev_r <= prev_nxt;
      TRAP_ACTIVE <= lvl_nxt != LVL_NONE;
    end
  end

  // Interrupt status, mask and output
  always_comb begin
    evt_nxt = evt_r;
    mask_nxt = mask_r;
    if (wr_pend_r && waddr_r == OFS_IRQ_STAT) begin
      evt_nxt = evt_r & ~HWDATA[EVT_N-1:0];
    end
    if (wr_pend_r && waddr_r == OFS_IRQ_MASK) begin
      mask_nxt = HWDATA[EVT_N-1:0];
    end
    evt_nxt[EV_CLASS_A] = evt_nxt[EV_CLASS_A] | take_a;
    evt_nxt[EV_CLASS_B] = evt_nxt[EV_CLASS_B] | take_b;
    evt_nxt[EV_NODE] = evt_nxt[EV_NODE] | take_node;
    evt_nxt[EV_SW] = evt_nxt[EV_SW] | take_sw;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      evt_r <= '0;
      mask_r <= RST_MASK;
      IRQ <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      mask_r <= mask_nxt;
      IRQ <= |(evt_nxt & mask_nxt);
    end
  end

  a_vec_segment: assert property (@(posedge CLK) disable iff (!RSTN)
    VEC_VALID |-> VEC.addr.seg == $past(seg_r))
    else $error("vector segment differs from programmed segment");

  a_vec_spacing: assert property (@(posedge CLK) disable iff (!RSTN)
    VEC_VALID |-> VEC.addr.off == (OFF_W'(VEC.num) << (3'($past(sc_r)) + 3'd2)))
    else $error("vector offset does not match spacing");

  a_trap_prompt: assert property (@(posedge CLK) disable iff (!RSTN)
    (|pend_r[3:0] && lvl_r != LVL_A && !rst_pend_r)
      |-> ##[1:2] (VEC_VALID && VEC.num inside {7'h02, 7'h04, 7'h06, 7'h08}))
    else $error("class A trap not vectored promptly");

  a_flag_record: assert property (@(posedge CLK) disable iff (!RSTN)
    (|cause) |=> ((flag_r & $past(cause)) == $past(cause)))
    else $error("trap cause not recorded in flag");

  a_no_preempt: assert property (@(posedge CLK) disable iff (!RSTN)
    ($past(lvl_r) == LVL_A && !$past(rst_pend_r))
      |-> !(VEC_VALID && VEC.num inside {7'h02, 7'h04, 7'h06, 7'h08, 7'h0A}
            && !$past(take_sw)))
    else $error("trap preempted a class A service");

  a_node_refused: assert property (@(posedge CLK) disable iff (!RSTN)
    (VEC_VALID && $past(TRAP_ACTIVE) && !$past(take_sw)) |-> !(VEC.num inside {[7'h41:7'h6F]}))
    else $error("node vectored during trap service");

  a_class_a_nums: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(take_a) |-> VEC.num == 7'(2 * (int'($past(a_sel)) + 1)))
    else $error("class A trap number wrong");

  a_class_b_shared: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(take_b) |-> (VEC.num == 7'h0A && VEC.addr.off == (16'h0028 << $past(sc_r))))
    else $error("class B vector wrong");

  a_reserved_unused: assert property (@(posedge CLK) disable iff (!RSTN)
    (VEC_VALID && !$past(take_sw)) |-> !(VEC.num inside {[7'h0B:7'h0F]}))
    else $error("reserved trap number raised by hardware");

  a_sw_number: assert property (@(posedge CLK) disable iff (!RSTN)
    (SW_TRAP_REQ && !VEC_VALID && !rst_pend_r && !sw_pend_r && pend_r == '0 && cause == '0
      && node_pend_r == '0) |-> ##2 (VEC_VALID && VEC.num == $past(SW_TRAP_NUM, 2)))
    else $error("software trap number not honoured");

  a_node_range: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(take_node) |-> (VEC.num inside {[7'h41:7'h61], [7'h6B:7'h6F]}))
    else $error("node trap number out of map");

  a_reset_entry: assert property (@(posedge CLK) disable iff (!RSTN)
    $fell(rst_pend_r) |-> (VEC_VALID && VEC.num == 7'h00 && VEC.addr.off == 16'h0000))
    else $error("reset entry vector wrong");
endmodule
`default_nettype wire

//--- rtl/itv_pkg.sv
`default_nettype none
package itv_pkg;
  // Widths
  localparam int NUM_W = 7;
  localparam int SEG_W = 8;
  localparam int OFF_W = 16;
  localparam int SC_W = 2;
  localparam int CAUSE_N = 9;
  localparam int EVT_N = 4;
  // Interrupt node groups, in input order
  localparam int CAN_N = 15;
  localparam int SER_N = 18;
  localparam int MISC_N = 5;
  localparam int NODE_N = CAN_N + SER_N + MISC_N;
  // Register byte offsets
  localparam logic [7:0] OFS_VEC_SEG = 8'h00;
  localparam logic [7:0] OFS_CPU_CTRL_ONE = 8'h04;
  localparam logic [7:0] OFS_TRAP_FLAG = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_SVC_STAT = 8'h14;
  // Values after reset
  localparam logic [SEG_W-1:0] RST_SEG = 8'h00;
  localparam logic [SC_W-1:0] RST_SC = 2'h0;
  localparam logic [EVT_N-1:0] RST_MASK = 4'h0;
  // Spacing code 0 means 4 bytes; each step doubles it
  localparam logic [2:0] SPACING_LOG2 = 3'h2;
  // Trap numbers
  localparam logic [NUM_W-1:0] TN_RESET = 7'h00;
  localparam logic [NUM_W-1:0] TN_SYSREQ0 = 7'h02;
  localparam logic [NUM_W-1:0] TN_STACK_OVF = 7'h04;
  localparam logic [NUM_W-1:0] TN_STACK_UNF = 7'h06;
  localparam logic [NUM_W-1:0] TN_SBRK = 7'h08;
  localparam logic [NUM_W-1:0] TN_CLASS_B = 7'h0A;
  localparam logic [NUM_W-1:0] TN_RSVD_FIRST = 7'h0B;
  localparam logic [NUM_W-1:0] TN_RSVD_LAST = 7'h0F;
  localparam logic [NUM_W-1:0] TN_CAN_BASE = 7'h41;
  localparam logic [NUM_W-1:0] TN_SER_BASE = 7'h50;
  localparam logic [NUM_W-1:0] TN_SER_LAST = 7'h61;
  localparam logic [NUM_W-1:0] TN_FREE_FIRST = 7'h62;
  localparam logic [NUM_W-1:0] TN_FREE_LAST = 7'h6A;
  localparam logic [NUM_W-1:0] TN_CTRL_UNIT1 = 7'h6B;
  localparam logic [NUM_W-1:0] TN_EOS = 7'h6F;
  // Trap flag bit positions
  localparam int FB_SYSREQ0 = 0;
  localparam int FB_STACK_OVF = 1;
  localparam int FB_STACK_UNF = 2;
  localparam int FB_SBRK = 3;
  localparam int FB_SYSREQ1 = 4;
  localparam int FB_BAD_OPCODE = 5;
  localparam int FB_ACCERR = 6;
  localparam int FB_PROT_FAULT = 7;
  localparam int FB_WORD_OPERAND = 8;
  localparam int CLASS_A_N = 4;
  // Interrupt status bit positions
  localparam int EV_CLASS_A = 0;
  localparam int EV_CLASS_B = 1;
  localparam int EV_NODE = 2;
  localparam int EV_SW = 3;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_B = 2'b01,
    LVL_A = 2'b10
  } itv_lvl_t;

  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic [OFF_W-1:0] off;
  } itv_addr_t;

  typedef struct packed {
    logic [NUM_W-1:0] num;
    itv_addr_t addr;
  } itv_vec_t;

  // Trap number of interrupt node input idx
  function automatic logic [NUM_W-1:0] itv_node_num(input int idx);
    if (idx < CAN_N) begin
      return NUM_W'(int'(TN_CAN_BASE) + idx);
    end else if (idx < CAN_N + SER_N) begin
      return NUM_W'(int'(TN_SER_BASE) + idx - CAN_N);
    end
    return NUM_W'(int'(TN_CTRL_UNIT1) + idx - CAN_N - SER_N);
  endfunction
endpackage
`default_nettype wire

//--- rtl/itv_sync.sv
`timescale 1ns/100ps
`default_nettype none
module itv_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] agree;

  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Output follows only once two late stages agree
      dout <= (agree & s3_r) | (~agree & dout);
    end
  end
endmodule
`default_nettype wire

//--- rtl/itv_vec_calc.sv
`timescale 1ns/100ps
`default_nettype none
module itv_vec_calc
  import itv_pkg::*;
(
  // Vector inputs
  input wire logic [NUM_W-1:0] num,
  input wire logic [SEG_W-1:0] seg,
  input wire logic [SC_W-1:0] sc,
  // Location
  output itv_addr_t addr
);
  logic [2:0] shift;

  assign shift = 3'(sc) + SPACING_LOG2;
  assign addr = {seg, OFF_W'(num) << shift};
endmodule
`default_nettype wire

//--- tb/itv_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module itv_cpu_model
  import itv_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Vector port
  input wire logic vec_valid,
  input wire itv_vec_t vec,
  // Return control
  input wire logic ret_cmd,
  input wire logic [3:0] ret_dly,
  output logic trap_ret,
  output logic bad_vec
);
  logic [3:0] cnt_r;
  logic busy_r;

  // Routine length is set per return, so returns come promptly or slowly
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      trap_ret <= 1'b0;
    end else begin
      trap_ret <= 1'b0;
      if (ret_cmd) begin
        busy_r <= 1'b1;
        cnt_r <= ret_dly;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        trap_ret <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  // Software traps in this bench never pick these numbers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_vec <= 1'b0;
    end else if (vec_valid && ((vec.num >= 7'h0B && vec.num <= 7'h0F) ||
                               (vec.num >= 7'h62 && vec.num <= 7'h6A))) begin
      bad_vec <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/itv_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module itv_top_tb_top
  import itv_pkg::*;
;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic HSEL, HWRITE, HREADYOUT, HRESP, SW_TRAP_REQ, TRAP_RET, VEC_VALID, TRAP_ACTIVE, IRQ;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS, SYSREQ_PIN;
  logic [2:0] HSIZE;
  logic [6:0] CORE_TRAP;
  logic [NUM_W-1:0] SW_TRAP_NUM;
  logic [NODE_N-1:0] NODE_REQ;
  itv_vec_t VEC;
  logic ret_cmd, bad_vec;
  logic [3:0] ret_dly;
  logic [SEG_W-1:0] seg_v;
  logic [SC_W-1:0] sc_v;
  logic [7:0] ofs_list [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h20};
  int err_total = 0;
  int comparisons = 0;

  always #50 CLK = ~CLK;

  itv_top i_dut (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .SYSREQ_PIN(SYSREQ_PIN),
    .CORE_TRAP(CORE_TRAP), .SW_TRAP_REQ(SW_TRAP_REQ), .SW_TRAP_NUM(SW_TRAP_NUM),
    .NODE_REQ(NODE_REQ), .TRAP_RET(TRAP_RET), .VEC_VALID(VEC_VALID), .VEC(VEC),
    .TRAP_ACTIVE(TRAP_ACTIVE), .IRQ(IRQ));

  itv_cpu_model i_cpu (.clk(CLK), .rst_n(RSTN), .vec_valid(VEC_VALID), .vec(VEC),
    .ret_cmd(ret_cmd), .ret_dly(ret_dly), .trap_ret(TRAP_RET), .bad_vec(bad_vec));

  task automatic close_out();
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [38:0] seen, input logic [38:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fail_wait(input string what);
    err_total++;
    $display("Error %s expected handshake seen timeout", what);
    close_out();
  endtask

  function automatic itv_vec_t vexp(input logic [NUM_W-1:0] n);
    itv_vec_t v;
    v.num = n;
    v.addr.seg = seg_v;
    v.addr.off = OFF_W'(n) << (SPACING_LOG2 + sc_v);
    return v;
  endfunction

  function automatic logic [NUM_W-1:0] node_num(input int i);
    if (i < 15) return 7'h41 + 7'(i);
    if (i < 33) return 7'h50 + 7'(i - 15);
    return 7'h6B + 7'(i - 33);
  endfunction

  task automatic wait_rdy();
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      if (HREADYOUT === 1'b1) break;
    end
    if (i == 20) fail_wait("hready");
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h00_0000, ofs};
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    wait_rdy();
    rd = HRDATA;
    check("hresp", 39'(HRESP), 39'h0);
  endtask

  task automatic wait_vec(input logic [NUM_W-1:0] n);
    int i;
    for (i = 0; i < 30; i++) begin
      @(posedge CLK);
      #1;
      if (VEC_VALID === 1'b1) break;
    end
    if (i == 30) fail_wait("vector");
    check("vector", VEC, vexp(n));
  endtask

  task automatic no_vec(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge CLK);
      #1;
      if (VEC_VALID !== 1'b0) hits++;
    end
    check("no vector", 39'(hits), 39'h0);
  endtask

  task automatic kick(input logic [6:0] core, input int node, input logic sw,
                      input logic [NUM_W-1:0] n);
    @(posedge CLK);
    CORE_TRAP <= core;
    NODE_REQ <= (node < 0) ? '0 : NODE_N'(1) << node;
    SW_TRAP_REQ <= sw;
    SW_TRAP_NUM <= n;
    @(posedge CLK);
    CORE_TRAP <= 7'h00;
    NODE_REQ <= '0;
    SW_TRAP_REQ <= 1'b0;
  endtask

  task automatic trap_return();
    int i;
    @(posedge CLK);
    ret_cmd <= 1'b1;
    @(posedge CLK);
    ret_cmd <= 1'b0;
    for (i = 0; i < 30; i++) begin
      @(posedge CLK);
      if (TRAP_RET === 1'b1) break;
    end
    if (i == 30) fail_wait("return");
    ret_dly <= ret_dly ^ 4'h7;
  endtask

  initial begin
    repeat (60000) @(posedge CLK);
    fail_wait("watchdog");
  end

  initial begin
    {HSEL, HWRITE, SW_TRAP_REQ, ret_cmd} = 4'h0;
    {HADDR, HWDATA} = 64'h0;
    HTRANS = 2'h0;
    HSIZE = 3'h2;
    SYSREQ_PIN = 2'h0;
    CORE_TRAP = 7'h00;
    SW_TRAP_NUM = 7'h00;
    NODE_REQ = '0;
    ret_dly = 4'h0;
    seg_v = 8'h00;
    sc_v = 2'h0;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    wait_vec(7'h00);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, ofs_list[k], 32'h0000_0000);
      check("reset read", 39'(rd), 39'h0);
    end
    // Class A from the core, then from the pin
    for (int k = 0; k < 3; k++) begin
      kick(7'(1 << k), -1, 1'b0, 7'h00);
      wait_vec(7'h04 + 7'(2 * k));
      check("active", 39'(TRAP_ACTIVE), 39'h1);
      trap_return();
    end
    SYSREQ_PIN <= 2'b01;
    wait_vec(7'h02);
    SYSREQ_PIN <= 2'b00;
    trap_return();
    // Four class B causes at once share one vector
    kick(7'h78, -1, 1'b0, 7'h00);
    wait_vec(7'h0A);
    no_vec(8);
    trap_return();
    SYSREQ_PIN <= 2'b10;
    wait_vec(7'h0A);
    SYSREQ_PIN <= 2'b00;
    trap_return();
    bus(1'b0, OFS_TRAP_FLAG, 32'h0000_0000);
    check("trap flags", 39'(rd), 39'h1FF);
    bus(1'b1, OFS_TRAP_FLAG, 32'h0000_01FF);
    bus(1'b0, OFS_TRAP_FLAG, 32'h0000_0000);
    check("trap flags", 39'(rd), 39'h0);
    // Segment and spacing, largest software trap number
    seg_v = 8'h5A;
    sc_v = 2'h1;
    bus(1'b1, OFS_VEC_SEG, 32'h0000_005A);
    bus(1'b1, OFS_CPU_CTRL_ONE, 32'h0000_0001);
    bus(1'b0, OFS_VEC_SEG, 32'h0000_0000);
    check("segment", 39'(rd), 39'h5A);
    kick(7'h00, -1, 1'b1, 7'h7F);
    wait_vec(7'h7F);
    sc_v = 2'h3;
    bus(1'b1, OFS_CPU_CTRL_ONE, 32'h0000_0003);
    bus(1'b0, OFS_CPU_CTRL_ONE, 32'h0000_0000);
    check("spacing", 39'(rd), 39'h3);
    kick(7'h00, -1, 1'b1, 7'h7F);
    wait_vec(7'h7F);
    sc_v = 2'h0;
    bus(1'b1, OFS_CPU_CTRL_ONE, 32'h0000_0000);
    kick(7'h00, -1, 1'b1, 7'h7F);
    wait_vec(7'h7F);
    kick(7'h00, -1, 1'b1, 7'h00);
    wait_vec(7'h00);
    for (int k = 0; k < NODE_N; k++) begin
      kick(7'h00, k, 1'b0, 7'h00);
      wait_vec(node_num(k));
    end
    // Nesting: B, node held off, A preempts, B waits behind A
    kick(7'h08, -1, 1'b0, 7'h00);
    wait_vec(7'h0A);
    kick(7'h00, 37, 1'b0, 7'h00);
    no_vec(10);
    kick(7'h01, -1, 1'b0, 7'h00);
    wait_vec(7'h04);
    kick(7'h10, -1, 1'b0, 7'h00);
    no_vec(10);
    bus(1'b0, OFS_SVC_STAT, 32'h0000_0000);
    check("service status", 39'(rd), 39'h406);
    trap_return();
    no_vec(6);
    trap_return();
    wait_vec(7'h0A);
    no_vec(6);
    trap_return();
    wait_vec(7'h6F);
    check("active", 39'(TRAP_ACTIVE), 39'h0);
    // Event status and mask
    check("irq", 39'(IRQ), 39'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0004);
    @(posedge CLK);
    #1;
    check("irq", 39'(IRQ), 39'h1);
    bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    check("status", 39'(rd), 39'hF);
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0004);
    @(posedge CLK);
    #1;
    check("irq", 39'(IRQ), 39'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
    check("status", 39'(rd), 39'hB);
    check("reserved vectors", 39'(bad_vec), 39'h0);
    close_out();
  end
endmodule
`default_nettype wire
